/* src/sleep_doze_watchdog_pkg.sv */
// Shared constants for the sleep, slowdown and watchdog block.
// Assumes a 32-bit APB register bus and 8-bit registers in the low lane.
package sleep_doze_watchdog_pkg;

    // Register byte addresses.
    localparam logic [7:0] ADDR_REGULATOR = 8'h00;
    localparam logic [7:0] ADDR_SLOWDOWN  = 8'h04;
    localparam logic [7:0] ADDR_WATCHDOG  = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;

    // Regulator control fields.
    localparam int BIT_REG_RESERVED  = 0;
    localparam int BIT_REG_LOW_POWER = 1;

    // Slowdown and idle control fields.
    localparam int BIT_IDLE_EN  = 7;
    localparam int BIT_SLOW_EN  = 6;
    localparam int BIT_RESTORE  = 5;
    localparam int BIT_SLOW_RET = 4;
    localparam int RATIO_LSB    = 0;
    localparam int RATIO_MSB    = 2;

    // Watchdog control fields.
    localparam int BIT_SOFT_EN  = 0;
    localparam int PERIOD_LSB   = 1;
    localparam int PERIOD_MSB   = 5;

    // Status fields.
    localparam int BIT_ST_SLEEP = 0;
    localparam int BIT_ST_IDLE  = 1;
    localparam int BIT_ST_WDT   = 2;
    localparam int BIT_ST_DOZE  = 3;

    // Reset values.
    localparam logic [7:0] RST_REGULATOR = 8'h01;
    localparam logic [7:0] RST_SLOWDOWN  = 8'h00;
    localparam logic [4:0] RST_PERIOD    = 5'h0B;
    localparam logic       RST_SOFT_EN   = 1'b0;

    // Watchdog mode configuration codes.
    localparam logic [1:0] WDT_MODE_OFF      = 2'h0;
    localparam logic [1:0] WDT_MODE_SOFT     = 2'h1;
    localparam logic [1:0] WDT_MODE_AWAKE    = 2'h2;
    localparam logic [1:0] WDT_MODE_ALWAYS   = 2'h3;

    // Watchdog time base: oscillator rate, base interval, base prescale.
    localparam int         LFO_FREQ_HZ    = 31000;
    localparam int         WDT_BASE_MS    = 1;
    localparam int         WDT_BASE_TICKS = 32;
    localparam logic [4:0] WDT_PS_MAX     = 5'h12;
    localparam int         WDT_CNT_W      = 24;

    // Slowdown divider.
    localparam int         DOZE_CNT_W     = 8;
    localparam logic [7:0] DOZE_FULL      = 8'hFF;
    localparam logic [2:0] DOZE_TOP_CODE  = 3'h7;

    // Power state of the core.
    typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_IDLE} power_state_t;

endpackage

/* src/wdt_timeout_counter.sv */
// Watchdog time-out counter advanced by low-frequency oscillator ticks.
// Assumes lfo_tick is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module wdt_timeout_counter
    import sleep_doze_watchdog_pkg::*;
#(
    parameter int CNT_W = WDT_CNT_W
)
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       lfo_tick,
    input  wire logic       clear,
    input  wire logic       active,
    input  wire logic [4:0] period_sel,
    output logic            timeout
);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             timeout;
    } cnt_state_t;

    cnt_state_t       st;
    cnt_state_t       next_st;
    logic [CNT_W-1:0] terminal;

    // Terminal count is the base prescale shifted by the period code; codes above WDT_PS_MAX give the unshifted base.
    always_comb
    begin
        if (period_sel > WDT_PS_MAX)
            terminal = CNT_W'(WDT_BASE_TICKS);
        else
            terminal = CNT_W'(WDT_BASE_TICKS) << period_sel;
    end

    // Count oscillator ticks; a clear or a disable holds the count at zero.
    always_comb
    begin
        next_st = st;
        next_st.timeout = 1'b0;
        if (clear || !active)
            next_st.count = '0;
        else if (lfo_tick)
        begin
            if (st.count == terminal - CNT_W'(1))
            begin
                next_st.count = '0;
                next_st.timeout = 1'b1;
            end
            else
                next_st.count = st.count + CNT_W'(1);
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign timeout = st.timeout;

    property p_expire;
        @(posedge pclk) disable iff (!presetn)
        (lfo_tick && active && !clear && st.count == terminal - CNT_W'(1))
            |=> timeout;
    endproperty
    a_expire: assert property (p_expire)
        else $error("Watchdog missed its terminal count.");

    property p_clear_blocks;
        @(posedge pclk) disable iff (!presetn)
        (clear || !active) |=> (!timeout && st.count == '0);
    endproperty
    a_clear_blocks: assert property (p_clear_blocks)
        else $error("Watchdog count survived a clear.");

    property p_reserved_min;
        @(posedge pclk) disable iff (!presetn)
        (period_sel > WDT_PS_MAX) |-> terminal == CNT_W'(WDT_BASE_TICKS);
    endproperty
    a_reserved_min: assert property (p_reserved_min)
        else $error("Reserved period code did not give minimum.");

endmodule // wdt_timeout_counter
`default_nettype wire

/* src/sleep_doze_watchdog.sv */
// Sleep, idle, CPU slowdown and watchdog control with an APB register file.
// Assumes core event inputs are one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module sleep_doze_watchdog
    import sleep_doze_watchdog_pkg::*;
#(
    parameter int WDT_W = WDT_CNT_W
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  watchdog_mode_cfg,
    input  wire logic        sleep_instr,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        isr_entry,
    input  wire logic        return_from_isr_instr,
    input  wire logic        irq_pending,
    input  wire logic        in_circuit_debug,
    input  wire logic        low_freq_internal_osc,
    output logic             cpu_clock_en,
    output logic             periph_clock_en,
    output logic             regulator_low_power,
    output logic             sleeping,
    output logic             idling,
    output logic             wake_event,
    output logic             watchdog_reset
);

    typedef struct packed {
        power_state_t          pstate;
        logic                  regulator_low_power_sel;
        logic                  idle_on_sleep_enable;
        logic                  cpu_slowdown_enable;
        logic                  restore_speed_on_isr;
        logic                  slowdown_on_return;
        logic [2:0]            ratio;
        logic [4:0]            watchdog_period_sel;
        logic                  watchdog_soft_enable;
        logic [DOZE_CNT_W-1:0] doze_cnt;
        logic [31:0]           rdata;
        logic                  slverr;
        logic                  wake;
        logic                  wdt_reset;
    } state_t;

    state_t                st;
    state_t                next_st;
    logic                  wdt_active;
    logic                  wdt_clear;
    logic                  wdt_timeout;
    logic                  doze_eff;
    logic                  setup;
    logic                  wr_en;
    logic [DOZE_CNT_W-1:0] doze_last;
    logic [7:0]            rd_byte;
    logic                  rd_ok;

    // Watchdog enable from the mode configuration and sleep state.
    always_comb
    begin
        case (watchdog_mode_cfg)
            WDT_MODE_ALWAYS: wdt_active = 1'b1;
            WDT_MODE_AWAKE:  wdt_active = (st.pstate != PS_SLEEP);
            WDT_MODE_SOFT:   wdt_active = st.watchdog_soft_enable;
            default:         wdt_active = 1'b0;
        endcase
    end

    // Slowdown applies only while stored enable is set and debug is off.
    assign doze_eff  = st.cpu_slowdown_enable && !in_circuit_debug;
    assign doze_last = DOZE_FULL >> (DOZE_TOP_CODE - st.ratio);

    // Clock gates towards the core and peripherals.
    assign cpu_clock_en = (st.pstate == PS_RUN)
                          && (!doze_eff || st.doze_cnt == '0);
    assign periph_clock_en = (st.pstate != PS_SLEEP);
    assign regulator_low_power = (st.pstate == PS_SLEEP)
                                 && st.regulator_low_power_sel;
    assign sleeping = (st.pstate == PS_SLEEP);
    assign idling = (st.pstate == PS_IDLE);
    assign wake_event = st.wake;
    assign watchdog_reset = st.wdt_reset;

    // APB phases: read data is captured in setup, writes land in access.
    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite && pstrb[0];
    assign pready = 1'b1;
    assign prdata = st.rdata;
    assign pslverr = st.slverr;

    // Read multiplexer over the mapped registers.
    always_comb
    begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        if (paddr == ADDR_REGULATOR)
        begin
            rd_byte[BIT_REG_RESERVED]  = 1'b1;
            rd_byte[BIT_REG_LOW_POWER] = st.regulator_low_power_sel;
        end
        else if (paddr == ADDR_SLOWDOWN)
        begin
            rd_byte[BIT_IDLE_EN] = st.idle_on_sleep_enable;
            rd_byte[BIT_SLOW_EN]  = st.cpu_slowdown_enable;
            rd_byte[BIT_RESTORE]  = st.restore_speed_on_isr;
            rd_byte[BIT_SLOW_RET] = st.slowdown_on_return;
            rd_byte[RATIO_MSB:RATIO_LSB] = st.ratio;
        end
        else if (paddr == ADDR_WATCHDOG)
        begin
            rd_byte[PERIOD_MSB:PERIOD_LSB] = st.watchdog_period_sel;
            rd_byte[BIT_SOFT_EN] = st.watchdog_soft_enable;
        end
        else if (paddr == ADDR_STATUS)
        begin
            rd_byte[BIT_ST_SLEEP] = (st.pstate == PS_SLEEP);
            rd_byte[BIT_ST_IDLE]  = (st.pstate == PS_IDLE);
            rd_byte[BIT_ST_WDT]   = wdt_active;
            rd_byte[BIT_ST_DOZE]  = doze_eff;
        end
        else
            rd_ok = 1'b0;
    end

    // Next state: bus writes, power sequencing, slowdown and watchdog.
    always_comb
    begin
        next_st = st;
        next_st.wake = 1'b0;
        next_st.wdt_reset = 1'b0;
        wdt_clear = clear_watchdog_instr;

        // Capture read data and error at the setup edge.
        if (setup)
        begin
            next_st.rdata  = {24'h000000, rd_byte};
            next_st.slverr = !rd_ok;
        end

        // Software writes; the reserved regulator bit is not stored.
        if (wr_en)
        begin
            if (paddr == ADDR_REGULATOR)
                next_st.regulator_low_power_sel = pwdata[BIT_REG_LOW_POWER];
            else if (paddr == ADDR_SLOWDOWN)
            begin
                next_st.idle_on_sleep_enable = pwdata[BIT_IDLE_EN];
                next_st.cpu_slowdown_enable  = pwdata[BIT_SLOW_EN];
                next_st.restore_speed_on_isr = pwdata[BIT_RESTORE];
                next_st.slowdown_on_return   = pwdata[BIT_SLOW_RET];
                next_st.ratio = pwdata[RATIO_MSB:RATIO_LSB];
            end
            else if (paddr == ADDR_WATCHDOG)
            begin
                next_st.watchdog_period_sel = pwdata[PERIOD_MSB:PERIOD_LSB];
                next_st.watchdog_soft_enable = pwdata[BIT_SOFT_EN];
            end
        end

        // Hardware slowdown updates override a same-cycle write.
        if (isr_entry && st.restore_speed_on_isr)
            next_st.cpu_slowdown_enable = 1'b0;
        else if (return_from_isr_instr && st.slowdown_on_return)
            next_st.cpu_slowdown_enable = 1'b1;

        // Power state sequencing.
        case (st.pstate)
            PS_RUN:
            begin
                if (sleep_instr && !irq_pending)
                begin
                    wdt_clear = 1'b1;
                    if (st.idle_on_sleep_enable)
                        next_st.pstate = PS_IDLE;
                    else
                        next_st.pstate = PS_SLEEP;
                end
                else if (wdt_timeout)
                    next_st.wdt_reset = 1'b1;
            end
            default:
            begin
                if (irq_pending || wdt_timeout)
                begin
                    next_st.pstate = PS_RUN;
                    next_st.wake = 1'b1;
                    wdt_clear = 1'b1;
                end
            end
        endcase

        // Slowdown divider runs only while the CPU is in run state.
        if (st.pstate != PS_RUN || !doze_eff)
            next_st.doze_cnt = '0;
        else if (st.doze_cnt >= doze_last)
            next_st.doze_cnt = '0;
        else
            next_st.doze_cnt = st.doze_cnt + DOZE_CNT_W'(1);
    end

    // State register; the watchdog period resets to two seconds.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
            st.pstate <= PS_RUN;
            st.regulator_low_power_sel <= RST_REGULATOR[BIT_REG_LOW_POWER];
            st.idle_on_sleep_enable <= RST_SLOWDOWN[BIT_IDLE_EN];
            st.cpu_slowdown_enable <= RST_SLOWDOWN[BIT_SLOW_EN];
            st.restore_speed_on_isr <= RST_SLOWDOWN[BIT_RESTORE];
            st.slowdown_on_return <= RST_SLOWDOWN[BIT_SLOW_RET];
            st.ratio <= RST_SLOWDOWN[RATIO_MSB:RATIO_LSB];
            st.watchdog_period_sel <= RST_PERIOD;
            st.watchdog_soft_enable <= RST_SOFT_EN;
        end
        else
            st <= next_st;
    end

    // Watchdog counter on oscillator ticks.
    wdt_timeout_counter #(
        .CNT_W      (WDT_W)
    ) u_wdt (
        .pclk       (pclk),
        .presetn    (presetn),
        .lfo_tick   (low_freq_internal_osc),
        .clear      (wdt_clear),
        .active     (wdt_active),
        .period_sel (st.watchdog_period_sel),
        .timeout    (wdt_timeout)
    );

    property p_idle_clocks;
        @(posedge pclk) disable iff (!presetn)
        (st.pstate == PS_IDLE) |-> (periph_clock_en && !cpu_clock_en);
    endproperty
    a_idle_clocks: assert property (p_idle_clocks)
        else $error("Idle did not keep only peripheral clocks.");

    property p_sleep_entry;
        @(posedge pclk) disable iff (!presetn)
        (st.pstate == PS_RUN && sleep_instr && !irq_pending
            && !st.idle_on_sleep_enable)
            |=> (sleeping && !periph_clock_en && !cpu_clock_en);
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("Sleep instruction did not enter full sleep.");

    property p_regulator;
        @(posedge pclk) disable iff (!presetn)
        regulator_low_power |-> (sleeping && st.regulator_low_power_sel);
    endproperty
    a_regulator: assert property (p_regulator)
        else $error("Regulator low power outside selected sleep.");

    property p_restore;
        @(posedge pclk) disable iff (!presetn)
        (isr_entry && st.restore_speed_on_isr) |=> !st.cpu_slowdown_enable;
    endproperty
    a_restore: assert property (p_restore)
        else $error("Interrupt entry did not clear slowdown.");

    property p_return;
        @(posedge pclk) disable iff (!presetn)
        (return_from_isr_instr && st.slowdown_on_return
            && !(isr_entry && st.restore_speed_on_isr))
            |=> st.cpu_slowdown_enable;
    endproperty
    a_return: assert property (p_return)
        else $error("Interrupt return did not set slowdown.");

    property p_debug_speed;
        @(posedge pclk) disable iff (!presetn)
        (in_circuit_debug && st.pstate == PS_RUN) |-> cpu_clock_en;
    endproperty
    a_debug_speed: assert property (p_debug_speed)
        else $error("Debug did not force full CPU speed.");

    property p_doze_gap;
        @(posedge pclk) disable iff (!presetn)
        (doze_eff && cpu_clock_en) ##1 (doze_eff && st.pstate == PS_RUN)
            |-> !cpu_clock_en;
    endproperty
    a_doze_gap: assert property (p_doze_gap)
        else $error("Slowdown let back-to-back CPU cycles through.");

    property p_sleep_timeout;
        @(posedge pclk) disable iff (!presetn)
        (wdt_timeout && st.pstate != PS_RUN)
            |=> (!watchdog_reset && wake_event && st.pstate == PS_RUN);
    endproperty
    a_sleep_timeout: assert property (p_sleep_timeout)
        else $error("Sleep time-out did not wake without reset.");

    property p_run_timeout;
        @(posedge pclk) disable iff (!presetn)
        (wdt_timeout && st.pstate == PS_RUN && !sleep_instr)
            |=> watchdog_reset;
    endproperty
    a_run_timeout: assert property (p_run_timeout)
        else $error("Awake time-out did not reset the device.");

    property p_mode_off;
        @(posedge pclk) disable iff (!presetn)
        (watchdog_mode_cfg == WDT_MODE_OFF) |-> !wdt_active;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("Watchdog active in off mode.");

endmodule // sleep_doze_watchdog
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench for the sleep, slowdown and watchdog block.
// Assumes the design package is compiled first; the bench drives all ports.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sleep_doze_watchdog_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        pready, pslverr;
    logic [1:0]  mode_cfg;
    logic        sleep_i, clr_i, isr_i, ret_i, irq, dbg, lfo;
    logic        cpu_en, per_en, lowp, sleeping, idling, wake, wdt_rst;
    int          n_errors, check_count, cycles;
    logic [7:0]  rd;
    logic        er, got_r, got_w;
    int          n;

    // Device under test with the full counter width.
    sleep_doze_watchdog #(.WDT_W(WDT_CNT_W)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_mode_cfg(mode_cfg), .sleep_instr(sleep_i),
        .clear_watchdog_instr(clr_i), .isr_entry(isr_i),
        .return_from_isr_instr(ret_i), .irq_pending(irq),
        .in_circuit_debug(dbg), .low_freq_internal_osc(lfo),
        .cpu_clock_en(cpu_en), .periph_clock_en(per_en),
        .regulator_low_power(lowp), .sleeping(sleeping), .idling(idling),
        .wake_event(wake), .watchdog_reset(wdt_rst));

    // Clock of 5 ns period and a cycle limit that cuts a hang short.
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t cycle limit reached", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Compare tasks: one for register values, one for single flags.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
        end
    endtask

    // One APB transfer: setup, then access held until pready is sampled.
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Counts edges until a reset request or wake pulse, up to a limit.
    task automatic wait_evt(input int lim);
        n = 0;
        got_r = 1'b0;
        got_w = 1'b0;
        while (n < lim && !got_r && !got_w)
        begin
            @(posedge pclk);
            n++;
            got_r = (wdt_rst === 1'b1);
            got_w = (wake === 1'b1);
        end
    endtask

    // Clears the watchdog, then watches for its outcome.
    task automatic wdt_run(input int lim);
        @(posedge pclk) clr_i <= 1'b1;
        @(posedge pclk) clr_i <= 1'b0;
        wait_evt(lim);
    endtask

    // Checks a reset request arriving near the expected tick count.
    task automatic wdt_expect(input int term);
        wdt_run(term + 10);
        chk_bit(got_r, 1'b1);
        chk_bit(n >= term - 2 && n <= term + 4, 1'b1);
    endtask

    task automatic pulse_sleep();
        @(posedge pclk) sleep_i <= 1'b1;
        @(posedge pclk) sleep_i <= 1'b0;
        #1;
    endtask

    // Reset values, reserved bit and an unmapped address.
    task automatic t_reset_values();
        apb(ADDR_REGULATOR, 1'b0, 8'h00); chk_reg(rd, 8'h01);
        apb(ADDR_SLOWDOWN, 1'b0, 8'h00);  chk_reg(rd, 8'h00);
        apb(ADDR_WATCHDOG, 1'b0, 8'h00);  chk_reg(rd, 8'h16);
        chk_bit(er, 1'b0);
        apb(8'h10, 1'b0, 8'h00);
        chk_bit(er, 1'b1);
        apb(ADDR_REGULATOR, 1'b1, 8'h01);
        apb(ADDR_REGULATOR, 1'b0, 8'h00); chk_reg(rd, 8'h01);
        apb(ADDR_REGULATOR, 1'b1, 8'h03);
        apb(ADDR_REGULATOR, 1'b0, 8'h00); chk_reg(rd, 8'h03);
        // A write with its low byte lane off leaves the register alone.
        pstrb <= 4'h0;
        apb(ADDR_REGULATOR, 1'b1, 8'h01);
        pstrb <= 4'hF;
        apb(ADDR_REGULATOR, 1'b0, 8'h00); chk_reg(rd, 8'h03);
    endtask

    // Full sleep with low-power regulator, then idle, both ended by irq.
    task automatic t_sleep_idle();
        #1 chk_bit(lowp, 1'b0);
        pulse_sleep();
        chk_bit(sleeping, 1'b1);
        chk_bit(per_en, 1'b0);
        chk_bit(lowp, 1'b1);
        @(posedge pclk) irq <= 1'b1;
        wait_evt(5); chk_bit(got_w, 1'b1);
        @(posedge pclk) irq <= 1'b0;
        #1 chk_bit(sleeping, 1'b0);
        apb(ADDR_SLOWDOWN, 1'b1, 8'h80);
        pulse_sleep();
        chk_bit(idling, 1'b1);
        chk_bit(per_en, 1'b1);
        chk_bit(cpu_en, 1'b0);
        chk_bit(lowp, 1'b0);
        @(posedge pclk) irq <= 1'b1;
        wait_evt(5); chk_bit(got_w, 1'b1);
        @(posedge pclk) irq <= 1'b0;
        apb(ADDR_SLOWDOWN, 1'b0, 8'h00); chk_reg(rd, 8'h80);
        apb(ADDR_SLOWDOWN, 1'b1, 8'h00);
    endtask

    // Slowdown ratio for every code, then the debug override.
    task automatic t_doze();
        for (int r = 0; r < 8; r++)
        begin
            apb(ADDR_SLOWDOWN, 1'b1, 8'h40 | r[7:0]);
            n = 0;
            repeat (256) @(posedge pclk) n += (cpu_en === 1'b1);
            chk_bit(n == (128 >> r), 1'b1);
        end
        dbg <= 1'b1;
        n = 0;
        repeat (256) @(posedge pclk) n += (cpu_en === 1'b1);
        chk_bit(n == 256, 1'b1);
        apb(ADDR_STATUS, 1'b0, 8'h00); chk_reg(rd, 8'h00);
        dbg <= 1'b0;
        apb(ADDR_SLOWDOWN, 1'b0, 8'h00); chk_reg(rd, 8'h47);
        apb(ADDR_STATUS, 1'b0, 8'h00); chk_reg(rd, 8'h08);
        apb(ADDR_SLOWDOWN, 1'b1, 8'h00);
        n = 0;
        repeat (64) @(posedge pclk) n += (cpu_en === 1'b1);
        chk_bit(n == 64, 1'b1);
    endtask

    // Hardware changes to the slowdown enable on isr entry and return.
    task automatic t_hw_slowdown();
        logic [7:0] setv [4] = '{8'h60, 8'h40, 8'h10, 8'h00};
        logic [7:0] expv [4] = '{8'h20, 8'h40, 8'h50, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            apb(ADDR_SLOWDOWN, 1'b1, setv[i]);
            @(posedge pclk)
            begin
                isr_i <= (i < 2);
                ret_i <= (i >= 2);
            end
            @(posedge pclk)
            begin
                isr_i <= 1'b0;
                ret_i <= 1'b0;
            end
            apb(ADDR_SLOWDOWN, 1'b0, 8'h00); chk_reg(rd, expv[i]);
        end
        // A write and an isr entry landing on one edge: hardware wins.
        apb(ADDR_SLOWDOWN, 1'b1, 8'h20);
        fork
            apb(ADDR_SLOWDOWN, 1'b1, 8'h60);
            begin
                repeat (2) @(posedge pclk);
                isr_i <= 1'b1;
                @(posedge pclk) isr_i <= 1'b0;
            end
        join
        apb(ADDR_SLOWDOWN, 1'b0, 8'h00); chk_reg(rd, 8'h20);
        apb(ADDR_SLOWDOWN, 1'b1, 8'h00);
    endtask

    // Watchdog modes, periods, clearing and time-out during sleep.
    task automatic t_watchdog();
        lfo <= 1'b1;
        mode_cfg <= WDT_MODE_ALWAYS;
        apb(ADDR_WATCHDOG, 1'b1, 8'h00);
        wdt_expect(32);
        apb(ADDR_WATCHDOG, 1'b1, 8'h02);
        wdt_expect(64);
        apb(ADDR_WATCHDOG, 1'b1, 8'h26);
        wdt_expect(32);
        repeat (4)
        begin
            wdt_run(20); chk_bit(got_r, 1'b0);
        end
        mode_cfg <= WDT_MODE_OFF;
        apb(ADDR_WATCHDOG, 1'b1, 8'h01);
        wdt_run(80); chk_bit(got_r, 1'b0);
        mode_cfg <= WDT_MODE_SOFT;
        wdt_expect(32);
        apb(ADDR_WATCHDOG, 1'b1, 8'h00);
        wdt_run(80); chk_bit(got_r, 1'b0);
        mode_cfg <= WDT_MODE_AWAKE;
        wdt_expect(32);
        pulse_sleep();
        wait_evt(80); chk_bit(got_r | got_w, 1'b0);
        mode_cfg <= WDT_MODE_ALWAYS;
        wait_evt(60); chk_bit(got_w, 1'b1);
        chk_bit(got_r, 1'b0);
        mode_cfg <= WDT_MODE_OFF;
        lfo <= 1'b0;
    endtask

    // Main sequence: hold reset for ten cycles, then run every scenario.
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        mode_cfg = WDT_MODE_OFF;
        {sleep_i, clr_i, isr_i, ret_i, irq, dbg, lfo} = '0;
        n_errors = 0;
        check_count = 0;
        cycles = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_sleep_idle();
        t_doze();
        t_hw_slowdown();
        t_watchdog();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
